// ### design/cmst_cfg.svh
// Register offsets, field positions, reset values and timing counts
// Notes on behaviour
// - Input sag code stored raw, saturates at 0x3B
// - Battery low code bits 5:0, 2.0V+N*25mV
// - Battery high code bits 5:0, 3.6V+N*25mV
// - Start ramp code bits 6:4, used at start
// - Current moves 10mA per step of 2^code periods
// - Ramp codes below five act as five
// - Bit 4 set turns safety timer off
// - Temp warning bits 3:0, 70C+N*5C
// - Countdown decrements once each second while running
// - Countdown read returns live count
// - Countdown writes are ignored
// - Load write with buck off stores pre-load only
// - Buck enable copies pre-load into countdown
// - Load write with buck on replaces countdown
// - Load in seconds 0..255, resets to 0xFF
// - Countdown expiry raises timer-expired event
// - Buck bit follows enable pin edges, writable
`ifndef CMST_CFG_SVH
`define CMST_CFG_SVH

`define CMST_A_SAG     8'h07
`define CMST_A_BLOW    8'h08
`define CMST_A_BHIGH   8'h09
`define CMST_A_SLEW    8'h0A
`define CMST_A_TOFF    8'h0B
`define CMST_A_COUNT   8'h0C
`define CMST_A_LOAD    8'h0D
`define CMST_A_BUCK    8'h0E
`define CMST_A_IOUT    8'h10

`define CMST_RST_SAG   8'h00
`define CMST_RST_BLOW  6'h00
`define CMST_RST_BHIGH 6'h00
`define CMST_RST_SLEW  3'h5
`define CMST_RST_TOFF  1'b0
`define CMST_RST_TWARN 4'h0
`define CMST_RST_LOAD  8'hFF
`define CMST_RST_IOUT  8'h0F

`define CMST_START_HI  6
`define CMST_START_LO  4
`define CMST_DEF_HI    2
`define CMST_DEF_LO    0
`define CMST_TOFF_BIT  4
`define CMST_TWARN_HI  3
`define CMST_TWARN_LO  0
`define CMST_BUCK_BIT  0

`define CMST_SAG_MAX   8'h3B
`define CMST_IOUT_MIN  8'h0F
`define CMST_IOUT_MAX  8'hE1
`define CMST_SLEW_MIN  3'h5

`define CMST_SEC_S     1
`define CMST_CLK_HZ    10000000
`define CMST_SEC_CYC   (`CMST_SEC_S * `CMST_CLK_HZ)
`define CMST_FAST_KHZ  5'd6
`define CMST_CLK_KHZ   5'd10

`endif

// ### design/cmst_pkg.sv
// Types shared by the charger monitor configuration block
package cmst_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmst_req_t;

  typedef struct packed {
    logic [7:0] input_sag_threshold;
    logic [5:0] battery_low_level;
    logic [5:0] battery_high_level;
    logic [3:0] temp_warning_level;
  } cmst_thr_t;

  typedef enum logic [1:0] {
    CMST_IDLE,
    CMST_START,
    CMST_TRACK
  } cmst_ramp_t;

endpackage

// ### design/cmst_top.sv
// Charger monitor thresholds, current ramp stepper and safety timer
`timescale 1ns/1ps
`include "cmst_cfg.svh"

module cmst_top #(
  parameter int unsigned SEC_CYCLES = `CMST_SEC_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire cmst_pkg::cmst_req_t reg_req,
  output logic [7:0]               reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                en_pin,
  output logic                     buck_on,
  output cmst_pkg::cmst_thr_t      thr,
  output logic [7:0]               iout_applied,
  output logic                     timer_expired
);
  import cmst_pkg::*;

  logic [7:0] sag_raw_q;
  logic [7:0] sag_eff_q;
  logic [5:0] blow_q;
  logic [5:0] bhigh_q;
  logic [2:0] start_slew_q;
  logic [2:0] def_slew_q;
  logic       toff_q;
  logic [3:0] twarn_q;
  logic [7:0] load_q;
  logic [7:0] count_q;
  logic       buck_q;
  logic       buck_prev_q;
  logic [7:0] iout_tgt_q;
  logic [7:0] applied_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       en_s1_q;
  logic       en_s2_q;
  logic       en_s3_q;
  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [7:0] step_q;
  logic [23:0] sec_q;
  logic       expired_q;
  logic       exp_pulse_q;
  cmst_ramp_t ramp_q;

  logic       wr;
  logic       en_rise;
  logic       en_fall;
  logic       buck_start;
  logic       running;
  logic       sec_tick;
  logic       load_now;
  logic       fast_tick;
  logic [4:0] acc_sum;
  logic [2:0] code_used;
  logic [7:0] step_len;
  logic       step_done;
  logic [7:0] rd_mux;

  function automatic logic [2:0] floor_code(input logic [2:0] c);
    floor_code = (c < `CMST_SLEW_MIN) ? `CMST_SLEW_MIN : c;
  endfunction

  assign wr         = reg_req.wr;
  assign en_rise    = en_s2_q & ~en_s3_q;
  assign en_fall    = ~en_s2_q & en_s3_q;
  assign buck_start = buck_q & ~buck_prev_q;
  assign running    = buck_q & ~toff_q;
  assign load_now   = wr && (reg_req.addr == `CMST_A_LOAD) && buck_q;

  // Register writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sag_raw_q    <= `CMST_RST_SAG;
      sag_eff_q    <= `CMST_RST_SAG;
      blow_q       <= `CMST_RST_BLOW;
      bhigh_q      <= `CMST_RST_BHIGH;
      start_slew_q <= `CMST_RST_SLEW;
      def_slew_q   <= `CMST_RST_SLEW;
      toff_q       <= `CMST_RST_TOFF;
      twarn_q      <= `CMST_RST_TWARN;
      load_q       <= `CMST_RST_LOAD;
      iout_tgt_q   <= `CMST_RST_IOUT;
    end
    else if (wr)
    begin
      case (reg_req.addr)
        `CMST_A_SAG:
        begin
          sag_raw_q <= reg_req.wdata;
          sag_eff_q <= (reg_req.wdata > `CMST_SAG_MAX) ? `CMST_SAG_MAX : reg_req.wdata;
        end
        `CMST_A_BLOW:  blow_q <= reg_req.wdata[5:0];
        `CMST_A_BHIGH: bhigh_q <= reg_req.wdata[5:0];
        `CMST_A_SLEW:
        begin
          start_slew_q <= reg_req.wdata[`CMST_START_HI:`CMST_START_LO];
          def_slew_q   <= reg_req.wdata[`CMST_DEF_HI:`CMST_DEF_LO];
        end
        `CMST_A_TOFF:
        begin
          toff_q  <= reg_req.wdata[`CMST_TOFF_BIT];
          twarn_q <= reg_req.wdata[`CMST_TWARN_HI:`CMST_TWARN_LO];
        end
        `CMST_A_LOAD:  load_q <= reg_req.wdata;
        `CMST_A_IOUT:  iout_tgt_q <= reg_req.wdata;
        default:       sag_raw_q <= sag_raw_q;
      endcase
    end
  end

  // Enable pin synchroniser and edge history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
    end
    else
    begin
      en_s1_q <= en_pin;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
    end
  end

  // Buck enable bit; pin edges win over a same-cycle write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buck_q      <= 1'b0;
      buck_prev_q <= 1'b0;
    end
    else
    begin
      buck_prev_q <= buck_q;
      if (en_rise)
      begin
        buck_q <= 1'b1;
      end
      else if (en_fall)
      begin
        buck_q <= 1'b0;
      end
      else if (wr && reg_req.addr == `CMST_A_BUCK)
      begin
        buck_q <= reg_req.wdata[`CMST_BUCK_BIT];
      end
    end
  end

  // One-second prescaler, restarted by any load
  assign sec_tick = running && (sec_q == 24'(SEC_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_q <= 24'h00_0000;
    end
    else if (!running || load_now || buck_start || sec_tick)
    begin
      sec_q <= 24'h00_0000;
    end
    else
    begin
      sec_q <= sec_q + 24'h00_0001;
    end
  end

  // Safety countdown
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= `CMST_RST_LOAD;
    end
    else if (load_now)
    begin
      count_q <= reg_req.wdata;
    end
    else if (buck_start)
    begin
      count_q <= load_q;
    end
    else if (sec_tick && count_q != 8'h00)
    begin
      count_q <= count_q - 8'h01;
    end
  end

  // Expiry raised once per load; an expiry in the cycle of a load write still fires, one in the buck start cycle does not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      expired_q   <= 1'b0;
      exp_pulse_q <= 1'b0;
    end
    else
    begin
      exp_pulse_q <= running && count_q == 8'h00 && !expired_q && !buck_start;
      if (load_now || buck_start)
      begin
        expired_q <= 1'b0;
      end
      else if (running && count_q == 8'h00)
      begin
        expired_q <= 1'b1;
      end
    end
  end

  // Fast oscillator ticks from the system clock by fractional accumulation
  assign acc_sum   = {1'b0, acc_q} + `CMST_FAST_KHZ;
  assign fast_tick = acc_sum >= `CMST_CLK_KHZ;
  assign acc_d     = fast_tick ? 4'(acc_sum - `CMST_CLK_KHZ) : acc_sum[3:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 4'h0;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  // Ramp phase: start code until the first target is reached
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_q <= CMST_IDLE;
    end
    else
    begin
      case (ramp_q)
        CMST_IDLE:
        begin
          if (buck_q)
          begin
            ramp_q <= CMST_START;
          end
        end
        CMST_START:
        begin
          if (!buck_q)
          begin
            ramp_q <= CMST_IDLE;
          end
          else if (applied_q == iout_tgt_q)
          begin
            ramp_q <= CMST_TRACK;
          end
        end
        CMST_TRACK:
        begin
          if (!buck_q)
          begin
            ramp_q <= CMST_IDLE;
          end
        end
        default:
        begin
          ramp_q <= CMST_IDLE;
        end
      endcase
    end
  end

  assign code_used = floor_code((ramp_q == CMST_START) ? start_slew_q : def_slew_q);
  assign step_len  = 8'h01 << code_used;
  assign step_done = fast_tick && (step_q == step_len - 8'h01);

  // Step timer counts fast oscillator periods
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_q <= 8'h00;
    end
    else if (!buck_q || applied_q == iout_tgt_q || step_done)
    begin
      step_q <= 8'h00;
    end
    else if (fast_tick)
    begin
      step_q <= step_q + 8'h01;
    end
  end

  // Applied current code, one 10 mA code per step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      applied_q <= `CMST_IOUT_MIN;
    end
    else if (!buck_q)
    begin
      applied_q <= `CMST_IOUT_MIN;
    end
    else if (step_done)
    begin
      if (applied_q < iout_tgt_q && applied_q < `CMST_IOUT_MAX)
      begin
        applied_q <= applied_q + 8'h01;
      end
      else if (applied_q > iout_tgt_q && applied_q > `CMST_IOUT_MIN)
      begin
        applied_q <= applied_q - 8'h01;
      end
    end
  end

  // Read data; reserved bits read zero
  always_comb
  begin
    case (reg_req.addr)
      `CMST_A_SAG:   rd_mux = sag_raw_q;
      `CMST_A_BLOW:  rd_mux = {2'b00, blow_q};
      `CMST_A_BHIGH: rd_mux = {2'b00, bhigh_q};
      `CMST_A_SLEW:  rd_mux = {1'b0, start_slew_q, 1'b0, def_slew_q};
      `CMST_A_TOFF:  rd_mux = {3'b000, toff_q, twarn_q};
      `CMST_A_COUNT: rd_mux = count_q;
      `CMST_A_LOAD:  rd_mux = load_q;
      `CMST_A_BUCK:  rd_mux = {7'h00, buck_q};
      `CMST_A_IOUT:  rd_mux = iout_tgt_q;
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_req.rd;
      if (reg_req.rd)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata                  = rdata_q;
  assign reg_rvalid                 = rvalid_q;
  assign buck_on                    = buck_q;
  assign thr                        = '{sag_eff_q, blow_q, bhigh_q, twarn_q};
  assign iout_applied               = applied_q;
  assign timer_expired              = exp_pulse_q;

endmodule

// ### tb/charger_monitor_config_safety_timer_test.sv
// Self-checking bench for the charger configuration and safety timer block
`timescale 1ns/1ps
module charger_monitor_config_safety_timer_test;
  import cmst_pkg::*;
  logic       clk, rst_n, en_pin, reg_rvalid, buck_on, timer_expired;
  logic [7:0] reg_rdata, iout_applied, v, a;
  cmst_req_t  reg_req;
  cmst_thr_t  thr;
  int         err_count, compares, seed, i, n;

  cmst_top #(.SEC_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .en_pin(en_pin), .buck_on(buck_on),
    .thr(thr), .iout_applied(iout_applied), .timer_expired(timer_expired));
  cmst_host u_host (.clk(clk), .req(reg_req), .rdata(reg_rdata), .rvalid(reg_rvalid));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    u_host.access(1'b0, ad, 8'h00);
    chk("read_valid", 8'h01, {7'h00, u_host.last_rv});
    chk("read_data", exp, u_host.last_rd);
  endtask

  // Target FF waits on the expiry pulse, else on the applied current
  task automatic wait_for(input logic [7:0] tgt, output int cnt);
    for (cnt = 1; cnt < 1000; cnt++)
    begin
      @(posedge clk);
      if (tgt == 8'hFF ? timer_expired === 1'b1 : iout_applied === tgt)
        return;
    end
    err_count++;
    report_and_stop();
  endtask

  function automatic logic [7:0] mask(input logic [7:0] ad);
    case (ad)
      8'h08, 8'h09: mask = 8'h3F;
      8'h0A:        mask = 8'h77;
      8'h0B:        mask = 8'h1F;
      default:      mask = 8'hFF;
    endcase
  endfunction

  initial
  begin
    err_count = 0;
    compares = 0;
    seed = 4468;
    rst_n = 1'b0;
    en_pin = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h0D, 8'hFF);
    rd(8'h0C, 8'hFF);
    rd(8'h0A, 8'h55);
    rd(8'h0F, 8'h00);
    for (i = 0; i < 30; i++)
    begin
      a = 8'(7 + i % 5);
      v = (i < 4) ? 8'(8'h3A + i * 8'h3B) : 8'($random(seed));
      u_host.access(1'b1, a, v);
      rd(a, v & mask(a));
      if (a == 8'h07)
        chk("sag", (v > 8'h3B) ? 8'h3B : v, thr.input_sag_threshold);
    end
    u_host.access(1'b1, 8'h0B, 8'h00);
    u_host.access(1'b1, 8'h0A, 8'h60);
    u_host.access(1'b1, 8'h0C, 8'h12);
    rd(8'h0C, 8'hFF);
    u_host.access(1'b1, 8'h0D, 8'h03);
    rd(8'h0C, 8'hFF);
    rd(8'h0D, 8'h03);
    u_host.access(1'b1, 8'h10, 8'h14);
    en_pin <= 1'b1;
    repeat (5) @(posedge clk);
    chk("buck_on", 8'h01, {7'h00, buck_on});
    rd(8'h0C, 8'h03);
    wait_for(8'hFF, n);
    chk("expiry_time", 8'h01, {7'h00, n >= 55 && n <= 65});
    // Start code 6 keeps the first step beyond the expiry
    chk("start_ramp", 8'h0F, iout_applied);
    rd(8'h0C, 8'h00);
    u_host.access(1'b1, 8'h0D, 8'h05);
    rd(8'h0C, 8'h05);
    u_host.access(1'b1, 8'h0B, 8'h10);
    repeat (60) @(posedge clk);
    rd(8'h0C, 8'h05);
    wait_for(8'h14, n);
    u_host.access(1'b1, 8'h10, 8'h10);
    wait_for(8'h10, n);
    for (i = 5; i < 7; i++)
    begin
      u_host.access(1'b1, 8'h0A, 8'(i));
      u_host.access(1'b1, 8'h10, 8'(i * 2 + 8));
      wait_for(8'(i * 2 + 7), n);
      wait_for(8'(i * 2 + 8), n);
      chk("step_time", 8'h01, {7'h00, n >= (10 << i) / 6 - 2 && n <= (10 << i) / 6 + 2});
    end
    en_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk("buck_off", 8'h00, {7'h00, buck_on});
    chk("iout_off", 8'h0F, iout_applied);
    report_and_stop();
  end
endmodule

// ### tb/cmst_checker.sv
// Port checks for the charger configuration and safety timer block
`timescale 1ns/1ps
`include "cmst_cfg.svh"
module cmst_checker #(
  parameter int unsigned SEC_CYCLES = `CMST_SEC_CYC
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire cmst_pkg::cmst_req_t reg_req,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_rvalid,
  input wire logic                en_pin,
  input wire logic                buck_on,
  input wire cmst_pkg::cmst_thr_t thr,
  input wire logic [7:0]          iout_applied,
  input wire logic                timer_expired
);
  import cmst_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sag_saturate_a: assert property (
    reg_req.wr && reg_req.addr == 8'h07 |=> thr.input_sag_threshold ==
      ($past(reg_req.wdata) > 8'h3B ? 8'h3B : $past(reg_req.wdata)))
    else $error("sag threshold wrong");
  low_level_a: assert property (
    reg_req.wr && reg_req.addr == 8'h08 |=> thr.battery_low_level == $past(reg_req.wdata[5:0]))
    else $error("battery low level wrong");
  high_level_a: assert property (
    reg_req.wr && reg_req.addr == 8'h09 |=> thr.battery_high_level == $past(reg_req.wdata[5:0]))
    else $error("battery high level wrong");
  temp_level_a: assert property (
    reg_req.wr && reg_req.addr == 8'h0B |=> thr.temp_warning_level == $past(reg_req.wdata[3:0]))
    else $error("temp warning level wrong");
  read_valid_a: assert property (reg_rvalid == $past(reg_req.rd))
    else $error("read valid not one cycle after read");
  pin_rise_a: assert property ($rose(en_pin) ##1 en_pin[*2] |-> ##1 buck_on)
    else $error("buck bit missed pin rise");
  step_size_a: assert property (
    buck_on && $stable(buck_on) |-> iout_applied == $past(iout_applied) ||
      iout_applied == $past(iout_applied) + 8'h01 || iout_applied == $past(iout_applied) - 8'h01)
    else $error("current moved more than one step");
  slew_floor_a: assert property (
    buck_on && $changed(iout_applied) |=> (!buck_on || $stable(iout_applied))[*8])
    else $error("current stepped too fast");
  iout_idle_a: assert property (!buck_on && !$past(buck_on) |-> iout_applied == 8'h0F)
    else $error("current not at minimum while off");
  expire_off_a: assert property (!buck_on && !$past(buck_on) |-> !timer_expired)
    else $error("expiry while buck off");
endmodule

bind cmst_top cmst_checker #(.SEC_CYCLES(SEC_CYCLES)) u_checker (.clk(clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .en_pin(en_pin),
  .buck_on(buck_on), .thr(thr), .iout_applied(iout_applied), .timer_expired(timer_expired));

// ### tb/cmst_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module cmst_host (
  input  wire logic           clk,
  output cmst_pkg::cmst_req_t req,
  input  wire logic [7:0]     rdata,
  input  wire logic           rvalid
);
  import cmst_pkg::*;
  logic [7:0] last_rd;
  logic       last_rv;

  initial req = '0;

  // Called just after a rising edge; request held one cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    last_rv = rvalid;
    last_rd = rdata;
    @(posedge clk);
  endtask
endmodule
